// ===== include/rmc_pkg.sv
// Behaviour
// - calibrate once after power-on and manual reset
// - auto-calibrate on temperature change when enabled
// - host calibration request honoured only in standby
// - flag temperature move beyond selected threshold
// - auto mode launches at once, else host
// - calibration run lasts about ten milliseconds
// - rssi timeout after limit times sixteen bits
// - preamble timeout after limit times sixteen bits
// - trigger field selects which timeouts run
// - decode three-bit mode field
// - enable blocks per decoded mode
// - power sub-blocks up in fixed order
// - transmit startup: 5us, ramp (not in OOK), half bit
// - receive startup from bandwidth table
// - receiver ready after startup time elapses
// - first rssi sample after evaluation delay
// - preamble flag pulses on each detection
package rmc_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned CAL_TIME_MS = 10;
    localparam int unsigned CAL_CYCLES = CAL_TIME_MS * 1000 * CLK_MHZ;
    localparam int unsigned TX_BASE_US = 5;
    localparam int unsigned TX_BASE_CYCLES = TX_BASE_US * CLK_MHZ;
    localparam int unsigned STEP_CYCLES = 8;
    localparam logic [2:0] MODE_SLEEP = 3'h0;
    localparam logic [2:0] MODE_STDBY = 3'h1;
    localparam logic [2:0] MODE_SYNTH_TRANSMIT_FREQ_MODE = 3'h2;
    localparam logic [2:0] MODE_TX = 3'h3;
    localparam logic [2:0] MODE_SYNTH_RECEIVE_FREQ_MODE = 3'h4;
    localparam logic [2:0] MODE_RX = 3'h5;
    localparam logic [2:0] TRIG_NONE = 3'h0;
    localparam logic [2:0] TRIG_RSSI = 3'h1;
    localparam logic [2:0] TRIG_PRE = 3'h6;
    localparam logic [2:0] TRIG_BOTH = 3'h7;
    // receive startup in us per bandwidth code 0..20 (2.6 kHz .. 250 kHz)
    localparam int unsigned RX_START_US [21] = '{2330, 1940, 1560, 1180, 984, 791, 601,
        504, 407, 313, 264, 215, 169, 144, 119, 97, 84, 71, 85, 74, 63};
    typedef enum logic [4:0] {
        RMC_PW_OFF = 5'b00001,
        RMC_PW_REG = 5'b00010,
        RMC_PW_SYN = 5'b00100,
        RMC_PW_WAIT = 5'b01000,
        RMC_PW_RDY = 5'b10000
    } rmc_pw_t;
endpackage : rmc_pkg

// ===== hw/rmc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; change accepted once stages two and three agree
module rmc_sync (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic din,
    output logic dout
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                dout <= s3_q;
            end
        end
    end
endmodule : rmc_sync
`default_nettype wire

// ===== hw/rmc_timeout.sv
`timescale 1ns/1ps
`default_nettype none
// one receive timeout: fires when limit*16 bit ticks pass without the event
module rmc_timeout (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic bit_tick,
    input wire logic [7:0] limit,
    input wire logic event_seen,
    output logic fired
);
    logic [11:0] cnt_q;
    logic done_q;
    // counter restarts while not running, so each rx entry starts fresh
    always_ff @(posedge clk) begin
        if (sys_rst || !run) begin
            cnt_q <= 12'h000;
            done_q <= 1'b0;
        end else if (event_seen || fired) begin
            done_q <= 1'b1;
        end else if (bit_tick && !done_q) begin
            cnt_q <= cnt_q + 12'h001;
        end
    end
    // one-cycle pulse when count reaches limit*16; zero limit disables
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fired <= 1'b0;
        end else begin
            fired <= run && !done_q && !event_seen && bit_tick && limit != 8'h00
                && (cnt_q + 12'h001) == {limit, 4'h0};
        end
    end
endmodule : rmc_timeout
`default_nettype wire

// ===== hw/rmc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module rmc_ctrl #(
    parameter int unsigned CAL_CYCLES = rmc_pkg::CAL_CYCLES,
    parameter int unsigned BIT_DIV = 100
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic manual_reset,
    input wire logic [2:0] mode_select,
    input wire logic fsk_mode,
    input wire logic ook_mode,
    input wire logic calibration_launch_bit,
    input wire logic auto_recalibrate_enable,
    input wire logic thermal_watch_disable,
    input wire logic [1:0] temperature_delta_select,
    input wire logic [7:0] temperature_now,
    input wire logic [2:0] receive_trigger_select,
    input wire logic [7:0] signal_level_wait_limit,
    input wire logic [7:0] preamble_wait_limit,
    input wire logic [7:0] sync_wait_limit,
    input wire logic [7:0] signal_strength_value,
    input wire logic [7:0] signal_strength_threshold,
    input wire logic preamble_detector_enable,
    input wire logic preamble_seen,
    input wire logic sync_match_flag,
    input wire logic [11:0] amplifier_ramp_time,
    input wire logic auto_freq_correct_enable,
    input wire logic [4:0] receive_bandwidth,
    input wire logic [4:0] correction_receive_bandwidth,
    input wire logic [11:0] signal_level_eval_time,
    output logic calibration_clear,
    output logic calibration_busy,
    output logic temperature_moved_flag,
    output logic timeout_irq,
    output logic rssi_flag,
    output logic preamble_found_flag,
    output logic en_regulator,
    output logic en_xosc,
    output logic en_synth,
    output logic synth_at_if,
    output logic en_transmitter,
    output logic en_receiver,
    output logic mode_ready,
    output logic rx_ready,
    output logic rssi_valid
);
    if (CAL_CYCLES < 1 || CAL_CYCLES > 2**27 || BIT_DIV < 2 || BIT_DIV > 65536) begin : g_chk
        $error("rmc_ctrl: bad parameters");
    end

    // external flags come from other domains
    logic manual_reset_s;
    logic preamble_s;
    logic sync_s;
    rmc_sync u_sync_mr (.clk(clk), .sys_rst(sys_rst), .din(manual_reset), .dout(manual_reset_s));
    rmc_sync u_sync_pre (.clk(clk), .sys_rst(sys_rst), .din(preamble_seen), .dout(preamble_s));
    rmc_sync u_sync_sy (.clk(clk), .sys_rst(sys_rst), .din(sync_match_flag), .dout(sync_s));

    // mode decode used for block enables and sequencing
    function automatic logic [3:0] mode_blocks(input logic [2:0] m);
        // {xosc, synth, tx, rx}
        case (m)
            rmc_pkg::MODE_SLEEP: mode_blocks = 4'h0;
            rmc_pkg::MODE_STDBY: mode_blocks = 4'h8;
            rmc_pkg::MODE_SYNTH_TRANSMIT_FREQ_MODE: mode_blocks = 4'hc;
            rmc_pkg::MODE_TX: mode_blocks = 4'he;
            rmc_pkg::MODE_SYNTH_RECEIVE_FREQ_MODE: mode_blocks = 4'hc;
            rmc_pkg::MODE_RX: mode_blocks = 4'hd;
            default: mode_blocks = 4'h8;
        endcase
    endfunction : mode_blocks

    // bit period divider
    logic [15:0] bdiv_q;
    logic bit_tick;
    always_ff @(posedge clk) begin
        if (sys_rst || bdiv_q == 16'(BIT_DIV - 1)) begin
            bdiv_q <= 16'h0000;
        end else begin
            bdiv_q <= bdiv_q + 16'h0001;
        end
    end
    assign bit_tick = (bdiv_q == 16'(BIT_DIV - 1));

    // power sequence: regulator, then synth, then wait startup, then ready
    rmc_pkg::rmc_pw_t pw_q;
    logic [2:0] mode_q;
    logic [3:0] want;
    logic [23:0] wait_q;
    logic [23:0] start_cycles;
    logic [4:0] bw_code;
    assign want = mode_blocks(mode_select);
    assign bw_code = auto_freq_correct_enable ? correction_receive_bandwidth
        : receive_bandwidth;
    always_comb begin
        start_cycles = 24'h000001;
        if (mode_select == rmc_pkg::MODE_TX) begin
            start_cycles = 24'(rmc_pkg::TX_BASE_CYCLES) + 24'(BIT_DIV / 2)
                + (ook_mode ? 24'h000000
                : 24'((amplifier_ramp_time * 5 / 4) * rmc_pkg::CLK_MHZ));
        end else if (mode_select == rmc_pkg::MODE_RX) begin
            start_cycles = (bw_code > 5'd20) ? 24'(rmc_pkg::RX_START_US[20] * rmc_pkg::CLK_MHZ)
                : 24'(rmc_pkg::RX_START_US[bw_code] * rmc_pkg::CLK_MHZ);
        end
    end
    // fixed order bring-up; any mode change restarts it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pw_q <= rmc_pkg::RMC_PW_OFF;
            mode_q <= rmc_pkg::MODE_SLEEP;
            wait_q <= 24'h000000;
        end else if (mode_select != mode_q) begin
            mode_q <= mode_select;
            pw_q <= rmc_pkg::RMC_PW_OFF;
            wait_q <= 24'h000000;
        end else begin
            case (pw_q)
                rmc_pkg::RMC_PW_OFF:
                    if (want[3]) begin
                        pw_q <= rmc_pkg::RMC_PW_REG;
                        wait_q <= 24'h000000;
                    end
                rmc_pkg::RMC_PW_REG: begin
                    wait_q <= wait_q + 24'h000001;
                    if (wait_q == 24'(rmc_pkg::STEP_CYCLES - 1)) begin
                        pw_q <= want[2] ? rmc_pkg::RMC_PW_SYN : rmc_pkg::RMC_PW_RDY;
                        wait_q <= 24'h000000;
                    end
                end
                rmc_pkg::RMC_PW_SYN: begin
                    wait_q <= wait_q + 24'h000001;
                    if (wait_q == 24'(rmc_pkg::STEP_CYCLES - 1)) begin
                        pw_q <= (want[1] || want[0]) ? rmc_pkg::RMC_PW_WAIT
                            : rmc_pkg::RMC_PW_RDY;
                        wait_q <= 24'h000000;
                    end
                end
                rmc_pkg::RMC_PW_WAIT: begin
                    wait_q <= wait_q + 24'h000001;
                    if (wait_q + 24'h000001 >= start_cycles) begin
                        pw_q <= rmc_pkg::RMC_PW_RDY;
                        wait_q <= 24'h000000;
                    end
                end
                rmc_pkg::RMC_PW_RDY: wait_q <= 24'h000000;
                default: pw_q <= rmc_pkg::RMC_PW_OFF;
            endcase
        end
    end
    // block enables follow the sequence stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            en_regulator <= 1'b0;
            en_xosc <= 1'b0;
            en_synth <= 1'b0;
            synth_at_if <= 1'b0;
            en_transmitter <= 1'b0;
            en_receiver <= 1'b0;
        end else begin
            en_regulator <= want[3] && pw_q != rmc_pkg::RMC_PW_OFF;
            en_xosc <= want[3] && pw_q != rmc_pkg::RMC_PW_OFF;
            en_synth <= want[2] && (pw_q == rmc_pkg::RMC_PW_SYN
                || pw_q == rmc_pkg::RMC_PW_WAIT || pw_q == rmc_pkg::RMC_PW_RDY);
            synth_at_if <= mode_q == rmc_pkg::MODE_SYNTH_RECEIVE_FREQ_MODE || mode_q == rmc_pkg::MODE_RX;
            en_transmitter <= want[1] && (pw_q == rmc_pkg::RMC_PW_WAIT
                || pw_q == rmc_pkg::RMC_PW_RDY);
            en_receiver <= want[0] && (pw_q == rmc_pkg::RMC_PW_WAIT
                || pw_q == rmc_pkg::RMC_PW_RDY);
        end
    end
    assign mode_ready = (pw_q == rmc_pkg::RMC_PW_RDY) && mode_q == mode_select;
    assign rx_ready = mode_ready && mode_q == rmc_pkg::MODE_RX;
    logic in_rx;
    assign in_rx = mode_select == rmc_pkg::MODE_RX && mode_q == rmc_pkg::MODE_RX;

    // rssi evaluation delay after receiver ready
    logic [11:0] rssi_cnt_q;
    always_ff @(posedge clk) begin
        if (sys_rst || !rx_ready) begin
            rssi_cnt_q <= 12'h000;
            rssi_valid <= 1'b0;
        end else if (!rssi_valid) begin
            rssi_cnt_q <= rssi_cnt_q + 12'h001;
            rssi_valid <= rssi_cnt_q + 12'h001 >= signal_level_eval_time;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rssi_flag <= 1'b0;
        end else begin
            rssi_flag <= rssi_valid && signal_strength_value > signal_strength_threshold;
        end
    end
    // preamble interrupt pulses on each rising detection
    logic pre_d_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pre_d_q <= 1'b0;
            preamble_found_flag <= 1'b0;
        end else begin
            pre_d_q <= preamble_s;
            preamble_found_flag <= preamble_detector_enable && rx_ready
                && preamble_s && !pre_d_q;
        end
    end

    // timeouts enabled by trigger field
    logic t_rssi_en;
    logic t_pre_en;
    logic t_sync_en;
    logic [2:0] fired;
    assign t_rssi_en = receive_trigger_select == rmc_pkg::TRIG_RSSI
        || receive_trigger_select == rmc_pkg::TRIG_BOTH;
    assign t_pre_en = receive_trigger_select == rmc_pkg::TRIG_PRE
        || receive_trigger_select == rmc_pkg::TRIG_BOTH;
    assign t_sync_en = receive_trigger_select == rmc_pkg::TRIG_PRE;
    rmc_timeout u_to_rssi (.clk(clk), .sys_rst(sys_rst), .run(in_rx && t_rssi_en),
        .bit_tick(bit_tick), .limit(signal_level_wait_limit), .event_seen(rssi_flag),
        .fired(fired[0]));
    rmc_timeout u_to_pre (.clk(clk), .sys_rst(sys_rst), .run(in_rx && t_pre_en),
        .bit_tick(bit_tick), .limit(preamble_wait_limit), .event_seen(preamble_s),
        .fired(fired[1]));
    rmc_timeout u_to_sync (.clk(clk), .sys_rst(sys_rst), .run(in_rx && t_sync_en),
        .bit_tick(bit_tick), .limit(sync_wait_limit), .event_seen(sync_s),
        .fired(fired[2]));
    assign timeout_irq = |fired;

    // temperature watch: reference taken at each calibration
    logic [7:0] temp_ref_q;
    logic [7:0] delta;
    logic [7:0] thresh;
    logic temp_trip;
    assign delta = (temperature_now > temp_ref_q) ? temperature_now - temp_ref_q
        : temp_ref_q - temperature_now;
    assign thresh = 8'(temperature_delta_select) * 8'h05 + 8'h05;
    assign temp_trip = !thermal_watch_disable && !boot_q && delta >= thresh;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            temperature_moved_flag <= 1'b0;
        end else begin
            temperature_moved_flag <= temp_trip;
        end
    end

    // calibration launch and run
    logic [26:0] cal_cnt_q;
    logic boot_q;
    logic mr_d_q;
    logic launch;
    logic host_req;
    assign host_req = calibration_launch_bit && mode_q == rmc_pkg::MODE_STDBY
        && mode_ready && fsk_mode;
    assign launch = !calibration_busy && (boot_q || (manual_reset_s && !mr_d_q)
        || (temp_trip && auto_recalibrate_enable) || host_req);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            boot_q <= 1'b1;
            mr_d_q <= 1'b0;
            calibration_busy <= 1'b0;
            cal_cnt_q <= 27'h0000000;
            temp_ref_q <= 8'h00;
        end else begin
            mr_d_q <= manual_reset_s;
            boot_q <= !launch && (boot_q || (manual_reset_s && !mr_d_q));
            if (launch) begin
                calibration_busy <= 1'b1;
                cal_cnt_q <= 27'h0000000;
                temp_ref_q <= temperature_now;
            end else if (calibration_busy) begin
                cal_cnt_q <= cal_cnt_q + 27'h0000001;
                if (cal_cnt_q == 27'(CAL_CYCLES - 1)) begin
                    calibration_busy <= 1'b0;
                end
            end
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            calibration_clear <= 1'b0;
        end else begin
            calibration_clear <= host_req && launch;
        end
    end

    a_cal_boot: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(sys_rst) |-> ##1 calibration_busy) else $error("no boot calibration");
    a_cal_len: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(calibration_busy) && !$past(sys_rst) |-> $past(cal_cnt_q) == 27'(CAL_CYCLES - 1))
        else $error("cal count");
    a_host_std: assert property (@(posedge clk) disable iff (sys_rst)
        calibration_clear |-> $past(mode_q) == rmc_pkg::MODE_STDBY) else $error("cal not stdby");
    a_temp_flag: assert property (@(posedge clk) disable iff (sys_rst)
        thermal_watch_disable && $past(thermal_watch_disable) |-> !temperature_moved_flag)
        else $error("temp flag while off");
    a_to_trig: assert property (@(posedge clk) disable iff (sys_rst)
        receive_trigger_select == rmc_pkg::TRIG_NONE && $past(receive_trigger_select)
        == rmc_pkg::TRIG_NONE |-> !timeout_irq) else $error("timeout while off");
    a_to_rx: assert property (@(posedge clk) disable iff (sys_rst)
        timeout_irq |-> $past(in_rx)) else $error("timeout outside rx");
    a_mode_sleep: assert property (@(posedge clk) disable iff (sys_rst)
        (mode_q == rmc_pkg::MODE_SLEEP) [*3] |-> !en_xosc && !en_synth) else $error("sleep on");
    a_rx_order: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(en_receiver) |-> en_synth && en_xosc) else $error("order");
    a_pre_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        preamble_found_flag |=> !preamble_found_flag) else $error("preamble pulse");
    c_cal: cover property (@(posedge clk) $fell(calibration_busy));
    c_to: cover property (@(posedge clk) timeout_irq);
    c_rx: cover property (@(posedge clk) $rose(rx_ready));
endmodule : rmc_ctrl
`default_nettype wire

// ===== sim/rmc_host.sv
`timescale 1ns/1ps
`default_nettype none
// companion processor: raises the launch bit on command and holds it until
// the device acknowledges; a refused request gets no answer, so the bench
// withdraws it with abort
module rmc_host (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic go,
    input wire logic abort,
    input wire logic use_flag,
    input wire logic temperature_moved_flag,
    input wire logic calibration_busy,
    input wire logic calibration_clear,
    output logic calibration_launch_bit
);
    // request on the go command in any mode, or later on the temperature flag when not busy
    always_ff @(posedge clk) begin
        if (sys_rst || calibration_clear || abort) begin
            calibration_launch_bit <= 1'h0;
        end else if (go) begin
            calibration_launch_bit <= 1'h1;
        end else if (use_flag && temperature_moved_flag && !calibration_busy) begin
            calibration_launch_bit <= 1'h1;
        end
    end
endmodule : rmc_host
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
    typedef struct packed {
        logic [2:0] mode;
        logic ook;
        logic afc;
        logic [15:0] lo;
        logic [15:0] hi;
        logic [5:0] exp_en;
        logic [5:0] mask;
    } rmc_row_t;
    typedef struct packed {
        logic [2:0] trig;
        logic [7:0] rl;
        logic [7:0] pl;
        logic [7:0] sl;
        logic sync;
        logic [15:0] due;
    } rmc_tmo_t;
    logic clk, sys_rst, manual_reset, fsk_mode, ook_mode, calibration_launch_bit;
    logic auto_recalibrate_enable, thermal_watch_disable, preamble_detector_enable;
    logic preamble_seen, sync_match_flag, auto_freq_correct_enable, go, abort, use_flag;
    logic [2:0] mode_select, receive_trigger_select;
    logic [1:0] temperature_delta_select;
    logic [7:0] temperature_now, signal_level_wait_limit, preamble_wait_limit;
    logic [7:0] sync_wait_limit, signal_strength_value, signal_strength_threshold;
    logic [11:0] amplifier_ramp_time, signal_level_eval_time;
    logic [4:0] receive_bandwidth, correction_receive_bandwidth;
    logic calibration_clear, calibration_busy, temperature_moved_flag, timeout_irq;
    logic rssi_flag, preamble_found_flag, en_regulator, en_xosc, en_synth, synth_at_if;
    logic en_transmitter, en_receiver, mode_ready, rx_ready, rssi_valid;
    int failures = 0;
    int comparisons = 0;
    int clears = 0;
    // status bits the waits can poll, by index
    wire [8:0] watch = {~calibration_busy, rssi_flag, temperature_moved_flag,
        preamble_found_flag, calibration_busy, timeout_irq, rssi_valid, rx_ready, mode_ready};
    wire [5:0] en = {en_regulator, en_xosc, en_synth, synth_at_if, en_transmitter, en_receiver};
    // mode rows: ready window in cycles (ramp code 8 = 10 us, bit 4 cycles), enables
    rmc_row_t mrows [10] = '{
        '{3'h0, 1'h0, 1'h0, 16'h0000, 16'h0000, 6'h00, 6'h3f},
        '{3'h1, 1'h0, 1'h0, 16'h0004, 16'h000c, 6'h30, 6'h3f},
        '{3'h2, 1'h0, 1'h0, 16'h0008, 16'h0014, 6'h08, 6'h0f},
        '{3'h3, 1'h0, 1'h0, 16'h05e4, 16'h05fa, 6'h0a, 6'h0b},
        '{3'h4, 1'h0, 1'h0, 16'h0008, 16'h0014, 6'h0c, 6'h0f},
        '{3'h5, 1'h0, 1'h0, 16'h18a2, 16'h18ba, 6'h09, 6'h0b},
        '{3'h1, 1'h0, 1'h0, 16'h0004, 16'h000c, 6'h30, 6'h3f},
        '{3'h3, 1'h1, 1'h0, 16'h01fc, 16'h0212, 6'h0a, 6'h0b},
        '{3'h1, 1'h0, 1'h0, 16'h0004, 16'h000c, 6'h30, 6'h3f},
        '{3'h5, 1'h0, 1'h1, 16'h20d6, 16'h20ee, 6'h09, 6'h0b}};
    // timeout rows: 64 cycles per limit unit; due 0 means silence
    rmc_tmo_t trows [6] = '{
        '{3'h0, 8'h01, 8'h01, 8'h01, 1'h0, 16'h0000},
        '{3'h1, 8'h01, 8'h02, 8'h03, 1'h0, 16'h0040},
        '{3'h6, 8'h01, 8'h02, 8'h03, 1'h0, 16'h0080},
        '{3'h7, 8'h03, 8'h02, 8'h01, 1'h0, 16'h0080},
        '{3'h6, 8'h01, 8'h00, 8'h03, 1'h0, 16'h00c0},
        '{3'h6, 8'h01, 8'h00, 8'h03, 1'h1, 16'h0000}};

    rmc_ctrl #(.CAL_CYCLES(50), .BIT_DIV(4)) DUT (.clk, .sys_rst, .manual_reset,
        .mode_select, .fsk_mode, .ook_mode, .calibration_launch_bit,
        .auto_recalibrate_enable, .thermal_watch_disable, .temperature_delta_select,
        .temperature_now, .receive_trigger_select, .signal_level_wait_limit,
        .preamble_wait_limit, .sync_wait_limit, .signal_strength_value,
        .signal_strength_threshold, .preamble_detector_enable, .preamble_seen,
        .sync_match_flag, .amplifier_ramp_time, .auto_freq_correct_enable,
        .receive_bandwidth, .correction_receive_bandwidth, .signal_level_eval_time,
        .calibration_clear, .calibration_busy, .temperature_moved_flag, .timeout_irq,
        .rssi_flag, .preamble_found_flag, .en_regulator, .en_xosc, .en_synth,
        .synth_at_if, .en_transmitter, .en_receiver, .mode_ready, .rx_ready, .rssi_valid);
    rmc_host host (.clk, .sys_rst, .go, .abort, .use_flag, .temperature_moved_flag,
        .calibration_busy, .calibration_clear, .calibration_launch_bit);

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    // count acknowledges, one expected per accepted request
    always @(posedge clk) begin
        if (calibration_clear === 1'h1) clears <= clears + 1;
    end

    task automatic finish_test();
        if (failures == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    task automatic skip(input int k);
        repeat (k) @(negedge clk);
    endtask : skip
    // polled at falling edges so clocked updates have landed
    task automatic wait_bit(input int b, input int lim, output int n);
        n = 0;
        while (watch[b] !== 1'h1 && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_bit
    task automatic host_cmd(input logic stop);
        @(posedge clk);
        if (stop) abort <= 1'h1;
        else go <= 1'h1;
        @(posedge clk);
        abort <= 1'h0;
        go <= 1'h0;
        @(negedge clk);
    endtask : host_cmd

    // whole run is about 19k cycles; this only cuts a hang short
    initial begin
        #600000;
        failures++;
        finish_test();
    end

    initial begin
        int n;
        int c0;
        {sys_rst, fsk_mode} <= 2'h3;
        {manual_reset, ook_mode, auto_recalibrate_enable, thermal_watch_disable} <= 4'h0;
        {preamble_detector_enable, preamble_seen, sync_match_flag} <= 3'h0;
        {auto_freq_correct_enable, go, abort, use_flag} <= 4'h0;
        mode_select <= 3'h0;
        receive_trigger_select <= 3'h0;
        temperature_delta_select <= 2'h0;
        temperature_now <= 8'h40;
        {signal_level_wait_limit, preamble_wait_limit, sync_wait_limit} <= 24'h0;
        signal_strength_value <= 8'h00;
        signal_strength_threshold <= 8'h10;
        amplifier_ramp_time <= 12'h008;
        signal_level_eval_time <= 12'h014;
        receive_bandwidth <= 5'h14;
        correction_receive_bandwidth <= 5'h10;
        repeat (6) @(posedge clk);
        `CHK({calibration_busy, mode_ready, timeout_irq}, 3'h0)
        sys_rst <= 1'h0;
        skip(1);
        wait_bit(4, 4, n);
        `CHK(n <= 2, 1'h1)
        wait_bit(8, 80, n);
        `CHK(n >= 46 && n <= 52, 1'h1)
        // mode decode, enables and startup latency per row
        foreach (mrows[i]) begin
            @(posedge clk);
            mode_select <= mrows[i].mode;
            ook_mode <= mrows[i].ook;
            auto_freq_correct_enable <= mrows[i].afc;
            skip(2);
            if (mrows[i].hi == 16'h0000) begin
                skip(20);
            end else begin
                wait_bit(0, 9000, n);
                `CHK(n + 2 >= mrows[i].lo && n + 2 <= mrows[i].hi, 1'h1)
            end
            `CHK(en & mrows[i].mask, mrows[i].exp_en)
        end
        `CHK(rx_ready, 1'h1)
        wait_bit(2, 60, n);
        `CHK(n >= 12 && n <= 26, 1'h1)
        @(posedge clk);
        signal_strength_value <= 8'h80;
        skip(1);
        wait_bit(7, 10, n);
        `CHK(n < 10, 1'h1)
        @(posedge clk);
        {preamble_detector_enable, preamble_seen} <= 2'h3;
        skip(1);
        wait_bit(5, 10, n);
        `CHK(n < 10, 1'h1)
        skip(1);
        `CHK(preamble_found_flag, 1'h0)
        @(posedge clk);
        {preamble_seen, signal_strength_value} <= 9'h000;
        // each entry to receive restarts the counters from zero
        foreach (trows[i]) begin
            @(posedge clk);
            mode_select <= rmc_pkg::MODE_STDBY;
            receive_trigger_select <= trows[i].trig;
            {signal_level_wait_limit, preamble_wait_limit} <= {trows[i].rl, trows[i].pl};
            {sync_wait_limit, sync_match_flag} <= {trows[i].sl, trows[i].sync};
            skip(20);
            @(posedge clk);
            mode_select <= rmc_pkg::MODE_RX;
            skip(1);
            wait_bit(3, 300, n);
            if (trows[i].due == 16'h0000) begin
                `CHK(n, 300)
            end else begin
                `CHK(n + 1 >= trows[i].due - 6 && n + 1 <= trows[i].due + 12, 1'h1)
            end
        end
        @(posedge clk);
        mode_select <= rmc_pkg::MODE_STDBY;
        receive_trigger_select <= rmc_pkg::TRIG_NONE;
        skip(2);
        wait_bit(0, 40, n);
        c0 = clears;
        host_cmd(1'h0);
        wait_bit(4, 6, n);
        `CHK(n < 6, 1'h1)
        wait_bit(8, 80, n);
        `CHK(n >= 44 && n <= 52, 1'h1)
        `CHK(clears - c0, 1)
        `CHK(calibration_launch_bit, 1'h0)
        // refused: sleep mode, then standby outside the keying personality
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            mode_select <= k[0] ? rmc_pkg::MODE_STDBY : rmc_pkg::MODE_SLEEP;
            fsk_mode <= ~k[0];
            skip(20);
            host_cmd(1'h0);
            wait_bit(4, 20, n);
            `CHK(n, 20)
            host_cmd(1'h1);
        end
        @(posedge clk);
        fsk_mode <= 1'h1;
        skip(20);
        // reference is the launch temperature 0x40
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            temperature_delta_select <= k[1:0];
            temperature_now <= 8'h40 + 8'(5 * k + 4);
            skip(8);
            `CHK(temperature_moved_flag, 1'h0)
            @(posedge clk);
            temperature_now <= 8'h40 + 8'(5 * k + 5);
            skip(8);
            `CHK(temperature_moved_flag, 1'h1)
        end
        @(posedge clk);
        thermal_watch_disable <= 1'h1;
        skip(8);
        `CHK(temperature_moved_flag, 1'h0)
        `CHK(calibration_busy, 1'h0)
        @(posedge clk);
        {thermal_watch_disable, auto_recalibrate_enable} <= 2'h1;
        skip(1);
        wait_bit(4, 10, n);
        `CHK(n < 10, 1'h1)
        wait_bit(8, 80, n);
        @(posedge clk);
        auto_recalibrate_enable <= 1'h0;
        skip(2);
        `CHK(temperature_moved_flag, 1'h0)
        @(posedge clk);
        {temperature_now, use_flag} <= 9'h0e1;
        skip(1);
        wait_bit(4, 12, n);
        `CHK(n < 12, 1'h1)
        @(posedge clk);
        use_flag <= 1'h0;
        wait_bit(8, 80, n);
        `CHK(temperature_moved_flag, 1'h0)
        @(posedge clk);
        manual_reset <= 1'h1;
        skip(1);
        wait_bit(4, 10, n);
        `CHK(n < 10, 1'h1)
        @(posedge clk);
        manual_reset <= 1'h0;
        wait_bit(8, 80, n);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
